/* File: oac_pkg.sv */
`default_nettype none
package oac_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  localparam int CTRL_W = 16;
  localparam int SEL_W = 8;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_P1_SEL_LOW = 14'h020A;
  localparam logic [IDX_W-1:0] IDX_P1_SEL_HIGH = 14'h020C;
  localparam logic [IDX_W-1:0] IDX_COMBO_CTRL = 14'h0C80;
  localparam logic [IDX_W-1:0] IDX_TRANSIMP_CTRL = 14'h0F00;

  // ----------------------------------------------------------------
  // combo_opamp_ctrl fields
  // ----------------------------------------------------------------
  localparam int COMBO_BLOCK_EN_BIT = 10;
  localparam int COMBO_SPEED_BIT = 9;
  localparam int COMBO_AMP_EN_BIT = 8;
  localparam int COMBO_NMUX_EN_BIT = 7;
  localparam int COMBO_NEG_INPUT_SELECT_LSB = 4;
  localparam int COMBO_PMUX_EN_BIT = 3;
  localparam int COMBO_PSEL_LSB = 0;
  localparam logic [CTRL_W-1:0] COMBO_RW_MASK = 16'h07BB;
  localparam logic [CTRL_W-1:0] COMBO_RST = 16'h0000;

  // input select encodings
  localparam logic [1:0] INSEL_EXT_PIN = 2'h0;
  localparam logic [1:0] INSEL_TRANSIMP = 2'h1;

  // ----------------------------------------------------------------
  // transimp_ctrl fields
  // ----------------------------------------------------------------
  localparam int TRANSIMP_EN_BIT = 0;
  localparam int TRANSIMP_SPEED_BIT = 1;
  localparam int TRANSIMP_PSEL_LSB = 6;
  localparam logic [CTRL_W-1:0] TRANSIMP_RW_MASK = 16'h00C3;
  localparam logic [CTRL_W-1:0] TRANSIMP_RST = 16'h0000;

  // ----------------------------------------------------------------
  // port 1 function select
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_RW_MASK = 8'hFF;
  localparam logic [SEL_W-1:0] SEL_RST = 8'h00;
  localparam int COMBO_PIN_LSB = 2;
  localparam int TRANSIMP_PIN_LSB = 5;
  localparam int PIN_GROUP_W = 3;

  // ----------------------------------------------------------------
  // reference setups and bus answers
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CFG_COMBO_EXT_LOWPWR = 16'h0588;
  localparam logic [CTRL_W-1:0] CFG_TRANSIMP_LOWSPD = 16'h0001;
  localparam logic [CTRL_W-1:0] CFG_TRANSIMP_HIGHSPD = 16'h0003;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: oac_field_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module oac_field_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RW_MASK = '1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH/8-1:0] wbe,
  // stored value
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_next;

  // read-only bits never take a written value
  always_comb begin
    q_next = q;
    for (int b = 0; b < WIDTH / 8; b++) begin
      if (wr_en && wbe[b]) begin
        q_next[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    q_next = q_next & RW_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= q_next;
    end
  end
endmodule // oac_field_reg
`default_nettype wire

/* File: oac_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - combo amp active only with amp, positive mux and negative mux enables set.
// - combo speed bit picks high-speed or low-power low-speed mode.
// - positive select connects combo input to external pin or transimpedance output.
// - value 0x0588 gives external inputs, low-power low-speed combo amp.
// - combo control is 16 bits, fixed field layout, reserved zero, reset zero.
// - combo output routed to comparator and converter, consumers select it.
// - combo pins need bits 2..4 set in both port1 select registers.
// - transimpedance enable bit 0 turns it on, bit 1 picks speed.
// - 0x01 gives low-speed enabled, 0x3 gives high-speed enabled.
// - transimpedance output routed to comparator, converter and combo inputs.
// - transimpedance pins need bits 5..7 set in both port1 select registers.
// - transimpedance control 16 bits, select at 7:6, others zero, reset zero.
// - both port1 select registers are 8-bit read-write, reset to zero.
module oac_regs
  import oac_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // combo amplifier controls
  output logic combo_block_enable,
  output logic combo_amp_active,
  output logic combo_high_speed,
  output logic combo_pos_from_pin,
  output logic combo_pos_from_transimp,
  output logic combo_neg_from_pin,
  output logic [1:0] combo_neg_select,
  output logic combo_out_routed,
  output logic combo_pins_enabled,
  // transimpedance amplifier controls
  output logic transimp_active,
  output logic transimp_high_speed,
  output logic [1:0] transimp_pos_select,
  output logic transimp_out_routed,
  output logic transimp_pins_enabled,
  // port 1 function select to pad mux
  output logic [SEL_W-1:0] port1_func_sel_low,
  output logic [SEL_W-1:0] port1_func_sel_high
);
  // ----------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [DATA_W/8-1:0] w_strb_reg;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  // response waits until the previous one is accepted
  wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  wire aw_full_next = aw_take || (aw_full_reg && !do_write);
  wire w_full_next = w_take || (w_full_reg && !do_write);
  wire bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);

  wire [IDX_W-1:0] wr_idx = aw_addr_reg[ADDR_W-1:2];
  wire wr_sel_low = do_write && (wr_idx == IDX_P1_SEL_LOW);
  wire wr_sel_high = do_write && (wr_idx == IDX_P1_SEL_HIGH);
  wire wr_combo = do_write && (wr_idx == IDX_COMBO_CTRL);
  wire wr_transimp = do_write && (wr_idx == IDX_TRANSIMP_CTRL);
  wire wr_hit = wr_sel_low || wr_sel_high || wr_combo || wr_transimp;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_full_next;
      s_axi_wready <= !w_full_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        // unmapped words answer slverr and change nothing
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel_low_q;
  logic [SEL_W-1:0] sel_high_q;
  logic [CTRL_W-1:0] combo_q;
  logic [CTRL_W-1:0] transimp_q;

  oac_field_reg #(.WIDTH(SEL_W), .RW_MASK(SEL_RW_MASK), .RST(SEL_RST)) u_sel_low (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_sel_low),
    .wdata(w_data_reg[SEL_W-1:0]),
    .wbe(w_strb_reg[0:0]),
    .q(sel_low_q)
  );

  oac_field_reg #(.WIDTH(SEL_W), .RW_MASK(SEL_RW_MASK), .RST(SEL_RST)) u_sel_high (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_sel_high),
    .wdata(w_data_reg[SEL_W-1:0]),
    .wbe(w_strb_reg[0:0]),
    .q(sel_high_q)
  );

  // reserved bits masked off inside the register
  oac_field_reg #(.WIDTH(CTRL_W), .RW_MASK(COMBO_RW_MASK), .RST(COMBO_RST)) u_combo (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_combo),
    .wdata(w_data_reg[CTRL_W-1:0]),
    .wbe(w_strb_reg[1:0]),
    .q(combo_q)
  );

  // reserved bits masked off inside the register
  oac_field_reg #(.WIDTH(CTRL_W), .RW_MASK(TRANSIMP_RW_MASK), .RST(TRANSIMP_RST)) u_transimp (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(wr_transimp),
    .wdata(w_data_reg[CTRL_W-1:0]),
    .wbe(w_strb_reg[1:0]),
    .q(transimp_q)
  );

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire [IDX_W-1:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_sel_low = rd_idx == IDX_P1_SEL_LOW;
  wire rd_sel_high = rd_idx == IDX_P1_SEL_HIGH;
  wire rd_combo = rd_idx == IDX_COMBO_CTRL;
  wire rd_transimp = rd_idx == IDX_TRANSIMP_CTRL;
  wire rd_hit = rd_sel_low || rd_sel_high || rd_combo || rd_transimp;
  wire [DATA_W-1:0] rd_word =
    rd_sel_low ? {{(DATA_W-SEL_W){1'b0}}, sel_low_q} :
    rd_sel_high ? {{(DATA_W-SEL_W){1'b0}}, sel_high_q} :
    rd_combo ? {{(DATA_W-CTRL_W){1'b0}}, combo_q} :
    rd_transimp ? {{(DATA_W-CTRL_W){1'b0}}, transimp_q} :
    {DATA_W{1'b0}};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // amplifier control decode
  // ----------------------------------------------------------------
  wire [1:0] combo_psel = combo_q[COMBO_PSEL_LSB +: 2];
  wire [1:0] combo_neg_input_select = combo_q[COMBO_NEG_INPUT_SELECT_LSB +: 2];
  wire combo_pmux = combo_q[COMBO_PMUX_EN_BIT];
  wire combo_nmux = combo_q[COMBO_NMUX_EN_BIT];
  // gp operation needs all three enables together
  wire combo_on = combo_q[COMBO_AMP_EN_BIT] && combo_pmux && combo_nmux;
  wire transimp_on = transimp_q[TRANSIMP_EN_BIT];
  wire combo_pins = (&sel_low_q[COMBO_PIN_LSB +: PIN_GROUP_W]) &&
                    (&sel_high_q[COMBO_PIN_LSB +: PIN_GROUP_W]);
  wire transimp_pins = (&sel_low_q[TRANSIMP_PIN_LSB +: PIN_GROUP_W]) &&
                       (&sel_high_q[TRANSIMP_PIN_LSB +: PIN_GROUP_W]);

  // registered so analog switches never see decode glitches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      combo_block_enable <= 1'b0;
      combo_amp_active <= 1'b0;
      combo_high_speed <= 1'b0;
      combo_pos_from_pin <= 1'b0;
      combo_pos_from_transimp <= 1'b0;
      combo_neg_from_pin <= 1'b0;
      combo_neg_select <= 2'h0;
      combo_out_routed <= 1'b0;
      combo_pins_enabled <= 1'b0;
      transimp_active <= 1'b0;
      transimp_high_speed <= 1'b0;
      transimp_pos_select <= 2'h0;
      transimp_out_routed <= 1'b0;
      transimp_pins_enabled <= 1'b0;
      port1_func_sel_low <= SEL_RST;
      port1_func_sel_high <= SEL_RST;
    end else begin
      combo_block_enable <= combo_q[COMBO_BLOCK_EN_BIT];
      combo_amp_active <= combo_on;
      combo_high_speed <= combo_q[COMBO_SPEED_BIT];
      combo_pos_from_pin <= combo_pmux && (combo_psel == INSEL_EXT_PIN);
      combo_pos_from_transimp <= combo_pmux && (combo_psel == INSEL_TRANSIMP);
      combo_neg_from_pin <= combo_nmux && (combo_neg_input_select == INSEL_EXT_PIN);
      combo_neg_select <= combo_neg_input_select;
      // consumers still pick this signal in their own selects
      combo_out_routed <= combo_on;
      combo_pins_enabled <= combo_pins;
      transimp_active <= transimp_on;
      transimp_high_speed <= transimp_q[TRANSIMP_SPEED_BIT];
      transimp_pos_select <= transimp_q[TRANSIMP_PSEL_LSB +: 2];
      transimp_out_routed <= transimp_on;
      transimp_pins_enabled <= transimp_pins;
      port1_func_sel_low <= sel_low_q;
      port1_func_sel_high <= sel_high_q;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_combo_active;
    @(posedge ref_clk) disable iff (reset)
    ##1 combo_amp_active == $past(combo_q[COMBO_AMP_EN_BIT] && combo_q[COMBO_PMUX_EN_BIT]
                                   && combo_q[COMBO_NMUX_EN_BIT]);
  endproperty
  a_combo_active: assert property (p_combo_active)
    else $error("combo active does not follow the three enables");

  property p_combo_speed;
    @(posedge ref_clk) disable iff (reset)
    $changed(combo_q[COMBO_SPEED_BIT]) |=> combo_high_speed == $past(combo_q[COMBO_SPEED_BIT]);
  endproperty
  a_combo_speed: assert property (p_combo_speed)
    else $error("combo speed mode did not follow its bit");

  property p_combo_pos;
    @(posedge ref_clk) disable iff (reset)
    combo_pos_from_transimp |-> !combo_pos_from_pin && $past(combo_q[COMBO_PMUX_EN_BIT])
                                && $past(combo_q[COMBO_PSEL_LSB +: 2]) == INSEL_TRANSIMP;
  endproperty
  a_combo_pos: assert property (p_combo_pos)
    else $error("combo positive input select inconsistent");

  property p_combo_ext_lowpwr;
    @(posedge ref_clk) disable iff (reset)
    (wr_combo && w_strb_reg[1:0] == 2'h3 && w_data_reg[CTRL_W-1:0] == CFG_COMBO_EXT_LOWPWR)
    |-> ##2 (combo_amp_active && !combo_high_speed && combo_pos_from_pin && combo_neg_from_pin
             && combo_block_enable);
  endproperty
  a_combo_ext_lowpwr: assert property (p_combo_ext_lowpwr)
    else $error("reference combo setup did not take effect");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (reset)
    ((combo_q & ~COMBO_RW_MASK) == '0) && ((transimp_q & ~TRANSIMP_RW_MASK) == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bit is set");

  property p_combo_routed;
    @(posedge ref_clk) disable iff (reset)
    combo_out_routed == combo_amp_active;
  endproperty
  a_combo_routed: assert property (p_combo_routed)
    else $error("combo routing disagrees with combo active");

  property p_combo_pins;
    @(posedge ref_clk) disable iff (reset)
    ##1 combo_pins_enabled == $past(sel_low_q[4] && sel_low_q[3] && sel_low_q[2]
                                     && sel_high_q[4] && sel_high_q[3] && sel_high_q[2]);
  endproperty
  a_combo_pins: assert property (p_combo_pins)
    else $error("combo pin function wrong");

  property p_transimp_on;
    @(posedge ref_clk) disable iff (reset)
    ##1 transimp_active == $past(transimp_q[0]) && transimp_high_speed == $past(transimp_q[1]);
  endproperty
  a_transimp_on: assert property (p_transimp_on)
    else $error("transimpedance enable or speed wrong");

  property p_transimp_hs;
    @(posedge ref_clk) disable iff (reset)
    (wr_transimp && w_strb_reg[0] && w_data_reg[7:0] == CFG_TRANSIMP_HIGHSPD[7:0])
    |-> ##2 (transimp_active && transimp_high_speed);
  endproperty
  a_transimp_hs: assert property (p_transimp_hs)
    else $error("high-speed transimpedance setup did not take effect");

  property p_transimp_ls;
    @(posedge ref_clk) disable iff (reset)
    (wr_transimp && w_strb_reg[0] && w_data_reg[7:0] == CFG_TRANSIMP_LOWSPD[7:0])
    |-> ##2 (transimp_active && !transimp_high_speed);
  endproperty
  a_transimp_ls: assert property (p_transimp_ls)
    else $error("low-speed transimpedance setup did not take effect");

  property p_transimp_pins;
    @(posedge ref_clk) disable iff (reset)
    ##1 transimp_pins_enabled == $past(sel_low_q[7] && sel_low_q[6] && sel_low_q[5]
                                        && sel_high_q[7] && sel_high_q[6] && sel_high_q[5]);
  endproperty
  a_transimp_pins: assert property (p_transimp_pins)
    else $error("transimpedance pin function wrong");

  property p_sel_reset;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (sel_low_q == '0 && sel_high_q == '0 && combo_q == '0 && transimp_q == '0);
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("register not zero after reset");

  property p_write_resp;
    @(posedge ref_clk) disable iff (reset)
    do_write |=> s_axi_bvalid && s_axi_bresp == $past(wr_hit ? RESP_OKAY : RESP_SLVERR);
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response missing or wrong");
endmodule // oac_regs
`default_nettype wire

/* File: tb_opamp_control_registers.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_opamp_control_registers
  import oac_pkg::*;
;
  logic ref_clk, reset;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [DATA_W/8-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, combo_neg_select, transimp_pos_select;
  logic combo_block_enable, combo_amp_active, combo_high_speed, combo_pos_from_pin;
  logic combo_pos_from_transimp, combo_neg_from_pin, combo_out_routed, combo_pins_enabled;
  logic transimp_active, transimp_high_speed, transimp_out_routed, transimp_pins_enabled;
  logic [SEL_W-1:0] port1_func_sel_low, port1_func_sel_high;
  int err_count = 0;
  int comparisons = 0;
  // expected register contents
  logic [15:0] m_combo, m_tri;
  logic [7:0] m_lo, m_hi;
  logic [15:0] combo_tab [6] = '{16'h0180, 16'h0108, 16'h0088, 16'h0189, 16'h021A, 16'h01BA};
  logic [15:0] tri_tab [5] = '{16'h0001, 16'h0003, 16'hFFFF, 16'h0040, 16'h0080};
  logic [7:0] lo_tab [6] = '{8'h1C, 8'h1C, 8'hE0, 8'h60, 8'hFF, 8'h00};
  logic [7:0] hi_tab [6] = '{8'h1C, 8'h0C, 8'hE0, 8'hE0, 8'hFF, 8'hFF};
  logic [IDX_W-1:0] idx_tab [4] = '{IDX_P1_SEL_LOW, IDX_P1_SEL_HIGH, IDX_COMBO_CTRL,
    IDX_TRANSIMP_CTRL};

  oac_regs dut (
    .ref_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .combo_block_enable, .combo_amp_active, .combo_high_speed,
    .combo_pos_from_pin, .combo_pos_from_transimp, .combo_neg_from_pin, .combo_neg_select,
    .combo_out_routed, .combo_pins_enabled, .transimp_active, .transimp_high_speed,
    .transimp_pos_select, .transimp_out_routed, .transimp_pins_enabled,
    .port1_func_sel_low, .port1_func_sel_high
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [31:0] model_val(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_COMBO_CTRL: return {16'h0000, m_combo};
      IDX_TRANSIMP_CTRL: return {16'h0000, m_tri};
      IDX_P1_SEL_LOW: return {24'h000000, m_lo};
      default: return {24'h000000, m_hi};
    endcase
  endfunction

  task automatic check_outs();
    logic [15:0] v;
    v = m_combo;
    chk({combo_block_enable, combo_amp_active, combo_high_speed, combo_pos_from_pin,
      combo_pos_from_transimp, combo_neg_from_pin, combo_neg_select, combo_out_routed},
      {v[10], v[8] & v[7] & v[3], v[9], v[3] & (v[1:0] == 2'h0), v[3] & (v[1:0] == 2'h1),
      v[7] & (v[5:4] == 2'h0), v[5:4],
      v[8] & v[7] & v[3]});
    chk({transimp_active, transimp_high_speed, transimp_pos_select, transimp_out_routed},
      {m_tri[0], m_tri[1], m_tri[7:6], m_tri[0]});
    chk({combo_pins_enabled, transimp_pins_enabled}, {(&m_lo[4:2]) & (&m_hi[4:2]),
      (&m_lo[7:5]) & (&m_hi[7:5])});
    chk({port1_func_sel_low, port1_func_sel_high}, {m_lo, m_hi});
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
      output logic [1:0] resp);
    logic aw_open, w_open;
    int n;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= addr;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= data;
    s_axi_bready <= 1'h1;
    aw_open = 1'h1;
    w_open = 1'h1;
    n = 0;
    while ((aw_open || w_open) && n < 100) begin
      @(posedge ref_clk);
      n++;
      if (aw_open && s_axi_awready === 1'h1) begin
        s_axi_awvalid <= 1'h0;
        aw_open = 1'h0;
      end
      if (w_open && s_axi_wready === 1'h1) begin
        s_axi_wvalid <= 1'h0;
        w_open = 1'h0;
      end
    end
    do begin
      @(posedge ref_clk);
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    chk(n < 100, 1'h1);
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
      output logic [1:0] resp);
    int n;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= addr;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s_axi_arready !== 1'h1 && n < 100);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 100);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(n < 100, 1'h1);
  endtask

  task automatic rd_reg(input logic [IDX_W-1:0] idx);
    logic [31:0] rd;
    logic [1:0] resp;
    axi_read({idx, 2'h0}, rd, resp);
    chk(resp, RESP_OKAY);
    chk(rd, model_val(idx));
  endtask

  // upper half carries junk: only the register's own width may stick
  task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [15:0] data);
    logic [1:0] resp;
    axi_write({idx, 2'h0}, {16'hA5A5, data}, resp);
    chk(resp, RESP_OKAY);
    case (idx)
      IDX_COMBO_CTRL: m_combo = data & 16'h07BB;
      IDX_TRANSIMP_CTRL: m_tri = data & 16'h00C3;
      IDX_P1_SEL_LOW: m_lo = data[7:0];
      default: m_hi = data[7:0];
    endcase
    repeat (2) @(posedge ref_clk);
    check_outs();
    rd_reg(idx);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset <= 1'h1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    {m_combo, m_tri, m_lo, m_hi} = '0;
    @(posedge ref_clk);
    check_outs();
    foreach (idx_tab[i]) rd_reg(idx_tab[i]);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] rd;
    logic [1:0] resp;
    reset <= 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    s_axi_awaddr <= 16'h0000;
    s_axi_araddr <= 16'h0000;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hF;
    do_reset();
    wr_reg(IDX_COMBO_CTRL, 16'h0588);
    wr_reg(IDX_COMBO_CTRL, 16'hFFFF);
    foreach (combo_tab[i]) wr_reg(IDX_COMBO_CTRL, combo_tab[i]);
    foreach (tri_tab[i]) wr_reg(IDX_TRANSIMP_CTRL, tri_tab[i]);
    foreach (lo_tab[i]) begin
      wr_reg(IDX_P1_SEL_LOW, {8'h5A, lo_tab[i]});
      wr_reg(IDX_P1_SEL_HIGH, {8'hC3, hi_tab[i]});
    end
    // unmapped place: refused, nothing stored, reads zero
    axi_write(16'h0004, 32'hFFFFFFFF, resp);
    chk(resp, RESP_SLVERR);
    axi_read(16'h0004, rd, resp);
    chk(resp, RESP_SLVERR);
    chk(rd, 32'h00000000);
    check_outs();
    wr_reg(IDX_COMBO_CTRL, 16'h0588);
    // only lane 0 may land: upper control byte keeps 0x05
    s_axi_wstrb <= 4'h1;
    axi_write({IDX_COMBO_CTRL, 2'h0}, 32'hFFFF7F3B, resp);
    s_axi_wstrb <= 4'hF;
    chk(resp, RESP_OKAY);
    m_combo = 16'h053B;
    rd_reg(IDX_COMBO_CTRL);
    check_outs();
    do_reset();
    wrap_up();
  end
endmodule // tb_opamp_control_registers
`default_nettype wire
